// ===== word_load_pkg.sv
package word_load_pkg;
  localparam int unsigned XLEN = 64;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned OFFSET_W = 16;
  localparam logic [1:0] FULL_OFFSET_BIG = 2'h3;
  localparam logic [1:0] FULL_OFFSET_LITTLE = 2'h0;
  localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
  localparam logic [31:0] ALL_BYTES = 32'hffffffff;

  typedef enum logic [1:0] {
    load_left_part,
    load_right_part,
    load_unsigned_word,
    load_indexed_fp_word
  } load_op_type;

  typedef enum logic [2:0] {
    exc_none,
    exc_tlb_refill,
    exc_tlb_invalid,
    exc_bus_error,
    exc_address_error,
    exc_reserved_instr
  } exc_type;
endpackage

// ===== load_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none
module load_addr_gen
#(
  parameter int unsigned XLEN = 64,
  parameter int unsigned OFFSET_W = 16
)
(
  input wire logic [XLEN-1:0] base_in,
  input wire logic [XLEN-1:0] index_in,
  input wire logic [OFFSET_W-1:0] offset_in,
  input wire logic indexed_in,
  output logic [XLEN-1:0] effective_addr_out,
  output logic misaligned_out
);
  logic [XLEN-1:0] addend;

  always_comb
  begin
    if (indexed_in)
    begin
      addend = index_in;
    end
    else
    begin
      addend = {{(XLEN-OFFSET_W){offset_in[OFFSET_W-1]}}, offset_in};
    end
    effective_addr_out = base_in + addend;
    misaligned_out = |(effective_addr_out[1:0] &
      word_load_pkg::WORD_ALIGN_MASK);
  end
endmodule // load_addr_gen
`default_nettype wire

// ===== load_byte_merge.sv
`timescale 1ns/10ps
`default_nettype none
module load_byte_merge
(
  input wire word_load_pkg::load_op_type op_in,
  input wire logic [2:0] addr_low_in,
  input wire logic big_endian_in,
  input wire logic [63:0] mem_dword_in,
  input wire logic [63:0] dest_old_in,
  output logic [63:0] result_out,
  output logic all_bytes_out
);
  logic [31:0] mem_word;
  logic [1:0] byte_sel;
  logic [4:0] shift;
  logic [31:0] lane_mask;
  logic [31:0] lane_data;
  logic [31:0] low_word;

  always_comb
  begin
    // byte and word picked from address and byte order
    mem_word = (addr_low_in[2] ^ big_endian_in) ? mem_dword_in[63:32] :
      mem_dword_in[31:0];
    byte_sel = addr_low_in[1:0] ^ {big_endian_in, big_endian_in};
    all_bytes_out = 1'b0;
    result_out = dest_old_in;
    shift = 5'h0;
    lane_mask = word_load_pkg::ALL_BYTES;
    lane_data = mem_word;
    unique case (op_in)
      word_load_pkg::load_right_part:
      begin
        shift = {byte_sel, 3'h0};
        lane_mask = word_load_pkg::ALL_BYTES >> shift;
        lane_data = mem_word >> shift;
        all_bytes_out = (byte_sel == 2'h0);
      end
      word_load_pkg::load_left_part:
      begin
        shift = {2'h3 - byte_sel, 3'h0};
        lane_mask = word_load_pkg::ALL_BYTES << shift;
        lane_data = mem_word << shift;
        all_bytes_out = 1'b1;
      end
      word_load_pkg::load_unsigned_word,
      word_load_pkg::load_indexed_fp_word:
      begin
        all_bytes_out = 1'b1;
      end
    endcase
    low_word = (dest_old_in[31:0] & ~lane_mask) | (lane_data & lane_mask);
    unique case (op_in)
      word_load_pkg::load_right_part:
      begin
        // partial right load keeps the upper half so a later left load
        // completes the sign extension
        result_out = all_bytes_out ? {{32{low_word[31]}}, low_word} :
          {dest_old_in[63:32], low_word};
      end
      word_load_pkg::load_left_part:
      begin
        result_out = {{32{low_word[31]}}, low_word};
      end
      word_load_pkg::load_unsigned_word:
      begin
        result_out = {32'h0, mem_word};
      end
      word_load_pkg::load_indexed_fp_word:
      begin
        result_out = {dest_old_in[63:32], mem_word};
      end
    endcase
  end
endmodule // load_byte_merge
`default_nettype wire

// ===== word_load_merge_unit.sv
// Notes on behaviour
// - offset form: address is base plus sign-extended 16-bit immediate.
// - right-part address names the least significant byte of the word.
// - right-part takes 1 to 4 low bytes from the aligned word.
// - right-part leaves destination bytes above the loaded ones unchanged.
// - right-part targets the low 32-bit half of the destination.
// - right-part loading all four bytes copies bit 31 into 63..32.
// - partial right-part: upper half kept unchanged in this design.
// - right then left, either order, yields a sign-extended word.
// - byte selection uses two low address bits and byte order.
// - unaligned loads never zero the upper half; signed unless right-part is partial.
// - right-part raises only tlb refill, tlb invalid and bus errors.
// - unsigned word load zero-extends the aligned word into a gpr.
// - unsigned word load faults on nonzero low two address bits.
// - unsigned word load can also raise bus or reserved instruction.
// - indexed fp load address is index plus base register.
// - indexed fp load writes the word into the fpr low half.
// - indexed fp load faults when low two address bits nonzero.
// - left-part puts 1 to 4 high bytes high, low bytes kept.
// - left-part always loads bit 31 and copies it into 63..32.
`timescale 1ns/10ps
`default_nettype none
module word_load_merge_unit
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire word_load_pkg::load_op_type req_op_in,
  input wire logic [63:0] base_in,
  input wire logic [63:0] index_in,
  input wire logic [15:0] offset_in,
  input wire logic [63:0] dest_old_in,
  input wire logic reserved_instr_in,
  input wire logic memory_byte_order_in,
  input wire logic user_order_flip_in,
  input wire logic mem_valid_in,
  input wire logic [63:0] mem_dword_in,
  input wire logic tlb_refill_in,
  input wire logic tlb_invalid_in,
  input wire logic bus_error_in,
  output logic req_ready_out,
  output logic mem_req_out,
  output logic [63:0] effective_addr_out,
  output logic [63:0] result_out,
  output logic result_valid_out,
  output logic gpr_we_out,
  output logic fpr_we_out,
  output logic exc_valid_out,
  output word_load_pkg::exc_type exc_code_out
);
  typedef enum logic {st_idle, st_wait_mem} state_type;

  state_type state_q, state_d;
  word_load_pkg::load_op_type op_q, op_d;
  word_load_pkg::exc_type exc_code_q, exc_code_d;
  logic [63:0] addr_q, addr_d;
  logic [63:0] old_q, old_d;
  logic [63:0] result_q, result_d;
  logic be_q, be_d;
  logic ready_q, ready_d;
  logic mem_req_q, mem_req_d;
  logic result_valid_q, result_valid_d;
  logic gpr_we_q, gpr_we_d;
  logic fpr_we_q, fpr_we_d;
  logic exc_valid_q, exc_valid_d;
  logic [63:0] ea;
  logic misaligned;
  logic cpu_byte_order;
  logic [63:0] merged;
  logic all_bytes;

  function automatic logic needs_alignment(word_load_pkg::load_op_type op);
    needs_alignment = (op == word_load_pkg::load_unsigned_word) ||
      (op == word_load_pkg::load_indexed_fp_word);
  endfunction

  // user mode may flip the memory byte order seen by the cpu
  assign cpu_byte_order = memory_byte_order_in ^ user_order_flip_in;

  load_addr_gen #(
    .XLEN(word_load_pkg::XLEN),
    .OFFSET_W(word_load_pkg::OFFSET_W)
  ) addr_gen (
    .base_in(base_in),
    .index_in(index_in),
    .offset_in(offset_in),
    .indexed_in(req_op_in == word_load_pkg::load_indexed_fp_word),
    .effective_addr_out(ea),
    .misaligned_out(misaligned)
  );

  load_byte_merge merge (
    .op_in(op_q),
    .addr_low_in(addr_q[2:0]),
    .big_endian_in(be_q),
    .mem_dword_in(mem_dword_in),
    .dest_old_in(old_q),
    .result_out(merged),
    .all_bytes_out(all_bytes)
  );

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    old_d = old_q;
    be_d = be_q;
    result_d = result_q;
    exc_code_d = exc_code_q;
    mem_req_d = 1'b0;
    result_valid_d = 1'b0;
    gpr_we_d = 1'b0;
    fpr_we_d = 1'b0;
    exc_valid_d = 1'b0;
    unique case (state_q)
      st_idle:
      begin
        if (req_valid_in)
        begin
          op_d = req_op_in;
          addr_d = ea;
          old_d = dest_old_in;
          be_d = cpu_byte_order;
          exc_code_d = word_load_pkg::exc_none;
          // faults known at request time skip the memory access
          if (req_op_in == word_load_pkg::load_unsigned_word &&
            reserved_instr_in)
          begin
            exc_valid_d = 1'b1;
            exc_code_d = word_load_pkg::exc_reserved_instr;
          end
          else if (needs_alignment(req_op_in) && misaligned)
          begin
            exc_valid_d = 1'b1;
            exc_code_d = word_load_pkg::exc_address_error;
          end
          else
          begin
            mem_req_d = 1'b1;
            state_d = st_wait_mem;
          end
        end
      end
      st_wait_mem:
      begin
        if (mem_valid_in)
        begin
          state_d = st_idle;
          // translation faults outrank a bus error on the same reply
          if (tlb_refill_in)
          begin
            exc_valid_d = 1'b1;
            exc_code_d = word_load_pkg::exc_tlb_refill;
          end
          else if (tlb_invalid_in)
          begin
            exc_valid_d = 1'b1;
            exc_code_d = word_load_pkg::exc_tlb_invalid;
          end
          else if (bus_error_in)
          begin
            exc_valid_d = 1'b1;
            exc_code_d = word_load_pkg::exc_bus_error;
          end
          else
          begin
            result_d = merged;
            result_valid_d = 1'b1;
            gpr_we_d = (op_q != word_load_pkg::load_indexed_fp_word);
            fpr_we_d = (op_q == word_load_pkg::load_indexed_fp_word);
          end
        end
      end
    endcase
    ready_d = (state_d == st_idle);
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= st_idle;
      op_q <= word_load_pkg::load_left_part;
      addr_q <= 64'h0;
      old_q <= 64'h0;
      be_q <= 1'b0;
      result_q <= 64'h0;
      exc_code_q <= word_load_pkg::exc_none;
      ready_q <= 1'b1;
      mem_req_q <= 1'b0;
      result_valid_q <= 1'b0;
      gpr_we_q <= 1'b0;
      fpr_we_q <= 1'b0;
      exc_valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      old_q <= old_d;
      be_q <= be_d;
      result_q <= result_d;
      exc_code_q <= exc_code_d;
      ready_q <= ready_d;
      mem_req_q <= mem_req_d;
      result_valid_q <= result_valid_d;
      gpr_we_q <= gpr_we_d;
      fpr_we_q <= fpr_we_d;
      exc_valid_q <= exc_valid_d;
    end
  end

  assign req_ready_out = ready_q;
  assign mem_req_out = mem_req_q;
  assign effective_addr_out = addr_q;
  assign result_out = result_q;
  assign result_valid_out = result_valid_q;
  assign gpr_we_out = gpr_we_q;
  assign fpr_we_out = fpr_we_q;
  assign exc_valid_out = exc_valid_q;
  assign exc_code_out = exc_code_q;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  logic accept;
  assign accept = req_valid_in && state_q == st_idle;

  offset_sum_a: assert property (
    accept && req_op_in != word_load_pkg::load_indexed_fp_word |=>
      effective_addr_out ==
      $past(base_in) + {{48{$past(offset_in[15])}}, $past(offset_in)})
    else $error("offset address sum wrong");

  index_sum_a: assert property (
    accept && req_op_in == word_load_pkg::load_indexed_fp_word |=>
      effective_addr_out == $past(base_in) + $past(index_in))
    else $error("indexed address sum wrong");

  unsigned_align_a: assert property (
    accept && req_op_in == word_load_pkg::load_unsigned_word &&
      !reserved_instr_in && ea[1:0] != 2'h0 |=>
      exc_valid_out && exc_code_out == word_load_pkg::exc_address_error &&
      !mem_req_out)
    else $error("unsigned load misalignment not faulted");

  fp_align_a: assert property (
    accept && req_op_in == word_load_pkg::load_indexed_fp_word &&
      ea[1:0] != 2'h0 |=>
      exc_valid_out && exc_code_out == word_load_pkg::exc_address_error)
    else $error("fp load misalignment not faulted");

  unaligned_nofault_a: assert property (
    accept && (req_op_in == word_load_pkg::load_left_part ||
      req_op_in == word_load_pkg::load_right_part) |=>
      mem_req_out && !exc_valid_out)
    else $error("unaligned load faulted early");

  unsigned_zero_a: assert property (
    result_valid_out && op_q == word_load_pkg::load_unsigned_word |->
      result_out[63:32] == 32'h0 && gpr_we_out && !fpr_we_out)
    else $error("unsigned load not zero-extended");

  right_upper_a: assert property (
    result_valid_out && op_q == word_load_pkg::load_right_part |->
      (addr_q[1:0] == (be_q ? word_load_pkg::FULL_OFFSET_BIG :
        word_load_pkg::FULL_OFFSET_LITTLE)) ?
      result_out[63:32] == {32{result_out[31]}} :
      result_out[63:32] == old_q[63:32])
    else $error("right load upper half wrong");

  left_sext_a: assert property (
    result_valid_out && op_q == word_load_pkg::load_left_part |->
      result_out[63:32] == {32{result_out[31]}})
    else $error("left load not sign-extended");

  right_exc_a: assert property (
    exc_valid_out && op_q == word_load_pkg::load_right_part |->
      exc_code_out inside {word_load_pkg::exc_tlb_refill,
        word_load_pkg::exc_tlb_invalid, word_load_pkg::exc_bus_error})
    else $error("right load raised illegal exception");

  reserved_fault_a: assert property (
    accept && req_op_in == word_load_pkg::load_unsigned_word &&
      reserved_instr_in |=>
      exc_valid_out && exc_code_out == word_load_pkg::exc_reserved_instr &&
      !mem_req_out)
    else $error("reserved unsigned load not faulted");

  fp_write_a: assert property (
    result_valid_out && op_q == word_load_pkg::load_indexed_fp_word |->
      fpr_we_out && !gpr_we_out && result_out[63:32] == old_q[63:32])
    else $error("fp load wrote wrong half or file");

  unaligned_gpr_a: assert property (
    result_valid_out && (op_q == word_load_pkg::load_left_part ||
      op_q == word_load_pkg::load_right_part) |->
      gpr_we_out && !fpr_we_out)
    else $error("unaligned load wrote wrong file");

  // a reply may come in the request cycle, so ready returns with its pulse
  reply_turn_a: assert property (
    mem_req_out |-> !req_ready_out ##1
      (req_ready_out == (result_valid_out || exc_valid_out)))
    else $error("ready during outstanding access");
endmodule // word_load_merge_unit
`default_nettype wire

// ===== mem_partner.sv
`timescale 1ns/10ps
`default_nettype none
module mem_partner
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic mem_req_in,
  input wire logic [63:0] data_in,
  input wire logic [2:0] fault_in,
  input wire logic [3:0] delay_in,
  output logic mem_valid_out,
  output logic [63:0] mem_dword_out,
  output logic tlb_refill_out,
  output logic tlb_invalid_out,
  output logic bus_error_out
);
  int cnt;
  initial
  begin
    mem_valid_out = 1'b0;
    mem_dword_out = 64'h0;
    {tlb_refill_out, tlb_invalid_out, bus_error_out} = 3'h0;
  end
  // data means nothing outside the reply pulse, so it keeps flipping
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt <= -1;
      mem_valid_out <= 1'b0;
      {tlb_refill_out, tlb_invalid_out, bus_error_out} <= 3'h0;
    end
    else
    begin
      mem_valid_out <= 1'b0;
      mem_dword_out <= ~mem_dword_out;
      {tlb_refill_out, tlb_invalid_out, bus_error_out} <= 3'h0;
      if (mem_req_in && delay_in != 4'h0)
        cnt <= int'(delay_in) - 1;
      else if (cnt > 0)
        cnt <= cnt - 1;
      else if (mem_req_in || cnt == 0)
      begin
        cnt <= -1;
        mem_valid_out <= 1'b1;
        mem_dword_out <= data_in;
        {tlb_refill_out, tlb_invalid_out, bus_error_out} <= fault_in;
      end
    end
  end
endmodule // mem_partner
`default_nettype wire

// ===== word_load_merge_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module word_load_merge_unit_tb;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  word_load_pkg::load_op_type req_op_in = word_load_pkg::load_left_part;
  logic [63:0] base_in = 64'h0;
  logic [63:0] index_in = 64'h0;
  logic [15:0] offset_in = 16'h0;
  logic [63:0] dest_old_in = 64'h0;
  logic reserved_instr_in = 1'b0;
  logic memory_byte_order_in = 1'b0;
  logic user_order_flip_in = 1'b0;
  logic mem_valid_in, tlb_refill_in, tlb_invalid_in, bus_error_in;
  logic [63:0] mem_dword_in, effective_addr_out, result_out;
  logic req_ready_out, mem_req_out, result_valid_out, gpr_we_out;
  logic fpr_we_out, exc_valid_out;
  word_load_pkg::exc_type exc_code_out, ec;
  logic [63:0] p_data = 64'h0;
  logic [2:0] p_fault = 3'h0;
  logic [3:0] p_delay = 4'h0;
  logic [63:0] er, ea;
  int seed = 85514;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  always #4 clock_in = ~clock_in;

  word_load_merge_unit i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid_in), .req_op_in(req_op_in), .base_in(base_in),
    .index_in(index_in), .offset_in(offset_in), .dest_old_in(dest_old_in),
    .reserved_instr_in(reserved_instr_in),
    .memory_byte_order_in(memory_byte_order_in),
    .user_order_flip_in(user_order_flip_in), .mem_valid_in(mem_valid_in),
    .mem_dword_in(mem_dword_in), .tlb_refill_in(tlb_refill_in),
    .tlb_invalid_in(tlb_invalid_in), .bus_error_in(bus_error_in),
    .req_ready_out(req_ready_out), .mem_req_out(mem_req_out),
    .effective_addr_out(effective_addr_out), .result_out(result_out),
    .result_valid_out(result_valid_out), .gpr_we_out(gpr_we_out),
    .fpr_we_out(fpr_we_out), .exc_valid_out(exc_valid_out),
    .exc_code_out(exc_code_out));

  mem_partner i_mem (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .mem_req_in(mem_req_out), .data_in(p_data), .fault_in(p_fault),
    .delay_in(p_delay), .mem_valid_out(mem_valid_in),
    .mem_dword_out(mem_dword_in), .tlb_refill_out(tlb_refill_in),
    .tlb_invalid_out(tlb_invalid_in), .bus_error_out(bus_error_in));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // mode 0 random faults, 1 clean, 2 clean and merging into last result
  task automatic run_load(input int op, input int low, input int mode);
    logic be;
    logic [1:0] b;
    logic [31:0] w, t, m;
    req_op_in = word_load_pkg::load_op_type'(op[1:0]);
    base_in = {$random(seed), $random(seed)};
    index_in = {$random(seed), $random(seed)};
    offset_in = 16'($random(seed));
    dest_old_in = (mode == 2) ? er : {$random(seed), $random(seed)};
    p_data = {$random(seed), $random(seed)};
    {memory_byte_order_in, user_order_flip_in} = 2'($random(seed));
    reserved_instr_in = (mode == 0) && (($random(seed) & 3) == 0);
    p_fault = 3'h0;
    if (mode == 0 && ($random(seed) & 3) == 0)
      p_fault = 3'($random(seed));
    p_delay = 4'($random(seed) & 3);
    base_in[2:0] = 3'(low) - ((op == 3) ? index_in[2:0] : offset_in[2:0]);
    ea = base_in + {{48{offset_in[15]}}, offset_in};
    if (op == 3)
      ea = base_in + index_in;
    be = memory_byte_order_in ^ user_order_flip_in;
    b = ea[1:0] ^ {be, be};
    w = (ea[2] ^ be) ? p_data[63:32] : p_data[31:0];
    m = 32'hffffffff >> (8 * b);
    if (op == 0)
      t = (w << (8 * (3 - b))) |
        (dest_old_in[31:0] & ~(32'hffffffff << (8 * (3 - b))));
    else
      t = (dest_old_in[31:0] & ~m) | (w >> (8 * b));
    case (op)
      0: er = {{32{t[31]}}, t};
      1: er = (b == 2'h0) ? {{32{t[31]}}, t} :
        {dest_old_in[63:32], t};
      2: er = {32'h0, w};
      default: er = {dest_old_in[63:32], w};
    endcase
    ec = word_load_pkg::exc_none;
    if (op == 2 && reserved_instr_in)
      ec = word_load_pkg::exc_reserved_instr;
    else if (op >= 2 && ea[1:0] != 2'h0)
      ec = word_load_pkg::exc_address_error;
    else if (p_fault[2])
      ec = word_load_pkg::exc_tlb_refill;
    else if (p_fault[1])
      ec = word_load_pkg::exc_tlb_invalid;
    else if (p_fault[0])
      ec = word_load_pkg::exc_bus_error;
    req_valid_in = 1'b1;
    @(posedge clock_in);
    #1 req_valid_in = 1'b0;
    for (int i = 0; i < 20 && result_valid_out !== 1'b1 &&
      exc_valid_out !== 1'b1; i++)
    begin
      @(posedge clock_in);
      #1;
    end
    check(64'({req_ready_out, result_valid_out, exc_valid_out}),
      (ec == word_load_pkg::exc_none) ? 64'h6 : 64'h5);
    check(effective_addr_out, ea);
    if (ec == word_load_pkg::exc_none)
    begin
      check(result_out, er);
      check(64'({gpr_we_out, fpr_we_out}),
        (op == 3) ? 64'h1 : 64'h2);
    end
    else
      check(64'(exc_code_out), 64'(ec));
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      $display("FAIL at %0t: timeout", $time);
      finish_test;
    end
  end

  initial
  begin
    repeat (6) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    check(64'({req_ready_out, mem_req_out, result_valid_out, gpr_we_out,
      fpr_we_out, exc_valid_out, exc_code_out}), 64'h100);
    check(result_out | effective_addr_out, 64'h0);
    $display("test reset done");
    for (int op = 0; op < 4; op++)
      for (int k = 0; k < 32; k++)
        run_load(op, k % 8, 0);
    $display("test sweep done");
    // left then right, then right then left, on one destination
    for (int k = 0; k < 16; k++)
    begin
      run_load(k / 8, k % 8, 1);
      run_load(1 - k / 8, (k * 3) % 8, 2);
    end
    $display("test merge done");
    finish_test;
  end
endmodule // word_load_merge_unit_tb
`default_nettype wire
